// File: pkg/supply_supervisor_pkg.sv
package supply_supervisor_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int FP_SETTLE_NS = 2000;
  localparam int NORM_SETTLE_NS = 150000;
  // Least times, so round up to whole cycles
  localparam int FP_SETTLE_CYCLES = (FP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int NORM_SETTLE_CYCLES = (NORM_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_CNT_W = 16;

  // ----------------------------------------
  // Register map (byte offsets)
  // ----------------------------------------
  localparam int ADR_W = 8;
  localparam logic [7:0] CTRL_HIGH_OFS = 8'h00;
  localparam logic [7:0] CTRL_LOW_OFS = 8'h04;
  localparam logic [7:0] FLAG_OFS = 8'h08;
  localparam logic [7:0] IRQ_STATUS_OFS = 8'h0C;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h10;
  localparam logic [7:0] STATE_OFS = 8'h14;

  // Sides: index 0 high side, 1 low side
  localparam int SIDE_HIGH = 0;
  localparam int SIDE_LOW = 1;
  localparam int SIDES = 2;

  // Flag / interrupt layout
  localparam int FLAG_W = 4;
  localparam int FLAG_TRIP = 0;
  localparam int FLAG_SETTLE = 2;

  // ----------------------------------------
  // Control register layout
  // ----------------------------------------
  typedef struct packed {
    logic [1:0] level;
    logic keepOn;
    logic resetEnable;
    logic fullPerf;
    logic enable;
  } ctrl_t;

  localparam int CTRL_W = 6;
  localparam ctrl_t CTRL_RESET = 6'h01;
  localparam logic [FLAG_W-1:0] FLAG_RESET = 4'h0;

endpackage : supply_supervisor_pkg

// File: hw/settle_timer.sv
`timescale 1ns/1ps
module settle_timer
  import supply_supervisor_pkg::*;
#(
  parameter int CntW = SETTLE_CNT_W,
  parameter logic [SETTLE_CNT_W-1:0] FpCycles = SETTLE_CNT_W'(FP_SETTLE_CYCLES),
  parameter logic [SETTLE_CNT_W-1:0] NormCycles = SETTLE_CNT_W'(NORM_SETTLE_CYCLES)
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic rstSync_n,
  // Control
  input wire logic active,
  input wire logic start,
  input wire logic skip,
  input wire logic fullPerf,
  // Status
  output logic settled,
  output logic expired
);

  logic [CntW-1:0] count_q;
  logic settled_q;
  logic expired_q;

  always_ff @(posedge clock or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      count_q <= '0;
      settled_q <= 1'b0;
      expired_q <= 1'b0;
    end
    else
    begin
      expired_q <= 1'b0;
      if (!active)
      begin
        count_q <= '0;
        settled_q <= 1'b0;
      end
      else if (skip)
      begin
        // Results honoured at once, no mask at all
        count_q <= '0;
        settled_q <= 1'b1;
      end
      else if (start)
      begin
        count_q <= fullPerf ? FpCycles : NormCycles;
        settled_q <= 1'b0;
      end
      else if (count_q != '0)
      begin
        count_q <= count_q - 1'b1;
        if (count_q == CntW'(1))
        begin
          settled_q <= 1'b1;
          expired_q <= 1'b1;
        end
      end
    end
  end

  assign settled = settled_q;
  assign expired = expired_q;

endmodule : settle_timer

// File: hw/supply_supervisor_events.sv
// Decided for this implementation: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
module supply_supervisor_events
  import supply_supervisor_pkg::*;
#(
  parameter logic [SETTLE_CNT_W-1:0] NormCycles = SETTLE_CNT_W'(NORM_SETTLE_CYCLES),
  parameter bit PucSkipsSettle = 1'b1
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADR_W-1:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Supply side
  input wire logic [SIDES-1:0] compTrip,
  input wire logic deepSleep,
  input wire logic powerUpClear,
  output logic [SIDES-1:0] compOn,
  output logic porRequest,
  output logic gpioHighZ,
  // Interrupt
  output logic irq
);

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic rstMeta_q;
  logic rstSync_n;

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rstMeta_q <= 1'b0;
      rstSync_n <= 1'b0;
    end
    else
    begin
      rstMeta_q <= 1'b1;
      rstSync_n <= rstMeta_q;
    end
  end

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  function automatic logic hit(input logic [ADR_W-1:0] adr, input logic [7:0] ofs);
    hit = (adr[ADR_W-1:2] == ofs[ADR_W-1:2]);
  endfunction : hit

  logic ack_q;
  logic [31:0] rdata_q;
  logic [31:0] readMux;
  logic wrEn;
  logic [SIDES-1:0] ctrlWr;
  logic flagWr;
  logic statusWr;
  logic maskWr;

  // Write lands on the edge that the master sees ack
  assign wrEn = cyc_i && stb_i && we_i && ack_q && sel_i[0];
  assign ctrlWr[SIDE_HIGH] = wrEn && hit(adr_i, CTRL_HIGH_OFS);
  assign ctrlWr[SIDE_LOW] = wrEn && hit(adr_i, CTRL_LOW_OFS);
  assign flagWr = wrEn && hit(adr_i, FLAG_OFS);
  assign statusWr = wrEn && hit(adr_i, IRQ_STATUS_OFS);
  assign maskWr = wrEn && hit(adr_i, IRQ_MASK_OFS);

  always_ff @(posedge clock or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      ack_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q <= cyc_i && stb_i && !ack_q;
      if (cyc_i && stb_i && !ack_q)
      begin
        rdata_q <= readMux;
      end
    end
  end

  assign ack_o = ack_q;
  assign dat_o = rdata_q;

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  ctrl_t ctrl_q [SIDES];
  logic [SIDES-1:0] flagEnable_q;
  logic pucDly_q;

  for (genvar s = 0; s < SIDES; s++)
  begin : g_ctrl
    always_ff @(posedge clock or negedge rstSync_n)
    begin
      if (!rstSync_n)
      begin
        ctrl_q[s] <= CTRL_RESET;
        flagEnable_q[s] <= 1'b1;
      end
      else if (ctrlWr[s])
      begin
        ctrl_q[s] <= ctrl_t'(dat_i[CTRL_W-1:0]);
        flagEnable_q[s] <= 1'b1;
      end
      else if (powerUpClear)
      begin
        ctrl_q[s] <= CTRL_RESET;
        if (!ctrl_q[s].enable)
        begin
          flagEnable_q[s] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      pucDly_q <= 1'b0;
    end
    else
    begin
      pucDly_q <= powerUpClear;
    end
  end

  // ----------------------------------------
  // Comparator power and settling
  // ----------------------------------------
  logic [SIDES-1:0] compOnPrev_q;
  logic [SIDES-1:0] settled;
  logic [SIDES-1:0] expired;
  logic [SIDES-1:0] settleStart;
  logic [SIDES-1:0] settleSkip;
  logic [SIDES-1:0] fpSel;

  for (genvar s = 0; s < SIDES; s++)
  begin : g_side
    ctrl_t ctrlNext;
    // A write restarts the mask, so its new mode must pick the length
    assign ctrlNext = ctrlWr[s] ? ctrl_t'(dat_i[CTRL_W-1:0]) : ctrl_q[s];
    assign fpSel[s] = ctrlNext.fullPerf;
    // Costs sleep current when kept on
    assign compOn[s] = ctrl_q[s].enable && (!deepSleep || ctrl_q[s].keepOn);
    // Comparator power-up, except right after a power-up clear, or any control write restarts the mask
    assign settleStart[s] = (compOn[s] && !compOnPrev_q[s]) || ctrlWr[s];
    assign settleSkip[s] = PucSkipsSettle && pucDly_q && compOn[s] && !compOnPrev_q[s];

    settle_timer #(
      .CntW(SETTLE_CNT_W),
      .FpCycles(SETTLE_CNT_W'(FP_SETTLE_CYCLES)),
      .NormCycles(NormCycles)
    ) u_timer (
      .clock(clock),
      .rstSync_n(rstSync_n),
      .active(compOn[s]),
      .start(settleStart[s]),
      .skip(settleSkip[s]),
      .fullPerf(fpSel[s]),
      .settled(settled[s]),
      .expired(expired[s])
    );
  end

  always_ff @(posedge clock or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      compOnPrev_q <= '0;
    end
    else
    begin
      compOnPrev_q <= compOn;
    end
  end

  // ----------------------------------------
  // Trip and settle flags
  // ----------------------------------------
  logic [SIDES-1:0] tripEvent;
  logic [FLAG_W-1:0] flag_q;
  logic [FLAG_W-1:0] flagSet;

  assign tripEvent = compTrip & compOn & settled & flagEnable_q;
  assign flagSet = {expired, tripEvent};

  // Writing zero clears; a set in the same cycle wins
  always_ff @(posedge clock or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      flag_q <= FLAG_RESET;
    end
    else if (flagWr)
    begin
      flag_q <= (flag_q & dat_i[FLAG_W-1:0]) | flagSet;
    end
    else
    begin
      flag_q <= flag_q | flagSet;
    end
  end

  // ----------------------------------------
  // Reset request and pins
  // ----------------------------------------
  logic porRequest_q;
  logic gpioHighZ_q;
  logic [SIDES-1:0] porCause;

  for (genvar s = 0; s < SIDES; s++)
  begin : g_por
    // Reset fires even when flag operation is off
    assign porCause[s] = compTrip[s] && compOn[s] && settled[s] && ctrl_q[s].resetEnable;
  end

  always_ff @(posedge clock or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      porRequest_q <= 1'b0;
      gpioHighZ_q <= 1'b0;
    end
    else
    begin
      porRequest_q <= |porCause;
      gpioHighZ_q <= (|flag_q[FLAG_TRIP +: SIDES]) && ((compOn & ~settled) != '0);
    end
  end

  assign porRequest = porRequest_q;
  assign gpioHighZ = gpioHighZ_q;

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  logic [FLAG_W-1:0] irqStatus_q;
  logic [FLAG_W-1:0] irqMask_q;
  logic irq_q;

  always_ff @(posedge clock or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      irqStatus_q <= FLAG_RESET;
      irqMask_q <= FLAG_RESET;
      irq_q <= 1'b0;
    end
    else
    begin
      if (statusWr)
      begin
        irqStatus_q <= (irqStatus_q & ~dat_i[FLAG_W-1:0]) | flagSet;
      end
      else
      begin
        irqStatus_q <= irqStatus_q | flagSet;
      end
      if (maskWr)
      begin
        irqMask_q <= dat_i[FLAG_W-1:0];
      end
      irq_q <= |(irqStatus_q & irqMask_q);
    end
  end

  assign irq = irq_q;

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  always_comb
  begin
    readMux = 32'h0000_0000;
    if (hit(adr_i, CTRL_HIGH_OFS))
      readMux[CTRL_W-1:0] = ctrl_q[SIDE_HIGH];
    else if (hit(adr_i, CTRL_LOW_OFS))
      readMux[CTRL_W-1:0] = ctrl_q[SIDE_LOW];
    else if (hit(adr_i, FLAG_OFS))
      readMux[FLAG_W-1:0] = flag_q;
    else if (hit(adr_i, IRQ_STATUS_OFS))
      readMux[FLAG_W-1:0] = irqStatus_q;
    else if (hit(adr_i, IRQ_MASK_OFS))
      readMux[FLAG_W-1:0] = irqMask_q;
    else if (hit(adr_i, STATE_OFS))
      readMux[3*SIDES-1:0] = {flagEnable_q, settled, compOn};
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  // Edges since a full-performance start on the high side; 0 when idle
  localparam logic [SETTLE_CNT_W-1:0] FP_AGE_END = SETTLE_CNT_W'(FP_SETTLE_CYCLES + 1);
  logic [SETTLE_CNT_W-1:0] fpAge_q;

  always_ff @(posedge clock or negedge rstSync_n)
  begin
    if (!rstSync_n)
    begin
      fpAge_q <= '0;
    end
    else if (!compOn[SIDE_HIGH] || settleSkip[SIDE_HIGH])
    begin
      fpAge_q <= '0;
    end
    else if (settleStart[SIDE_HIGH])
    begin
      fpAge_q <= fpSel[SIDE_HIGH] ? SETTLE_CNT_W'(1) : '0;
    end
    else if (fpAge_q != '0 && fpAge_q != FP_AGE_END)
    begin
      fpAge_q <= fpAge_q + 1'b1;
    end
  end

  property p_fpMask;
    @(posedge clock) disable iff (!rstSync_n)
    (fpAge_q != '0) |-> (settled[SIDE_HIGH] == (fpAge_q == FP_AGE_END));
  endproperty
  a_fpMask: assert property (p_fpMask) else $error("full-performance mask not 250 cycles");

  property p_normLonger;
    @(posedge clock) disable iff (!rstSync_n)
    (compOn[0] && !compOnPrev_q[0] && !pucDly_q && !fpSel[0]) |-> ##250 (!settled[0] || !compOn[0]);
  endproperty
  a_normLonger: assert property (p_normLonger) else $error("normal mask as short as full-performance");

  property p_tripFlag;
    @(posedge clock) disable iff (!rstSync_n)
    tripEvent[0] |=> flag_q[FLAG_TRIP];
  endproperty
  a_tripFlag: assert property (p_tripFlag) else $error("trip did not set flag");

  property p_tripPor;
    @(posedge clock) disable iff (!rstSync_n)
    (compTrip[1] && compOn[1] && settled[1] && ctrl_q[1].resetEnable) |=> porRequest;
  endproperty
  a_tripPor: assert property (p_tripPor) else $error("trip with reset enable gave no reset");

  property p_pinsFloat;
    @(posedge clock) disable iff (!rstSync_n)
    ((|flag_q[FLAG_TRIP +: SIDES]) && compOn[0] && !settled[0]) |=> gpioHighZ;
  endproperty
  a_pinsFloat: assert property (p_pinsFloat) else $error("pins driven while tripped and settling");

  property p_sleepOff;
    @(posedge clock) disable iff (!rstSync_n)
    (deepSleep && !ctrl_q[0].keepOn) |-> !compOn[0];
  endproperty
  a_sleepOff: assert property (p_sleepOff) else $error("comparator on in deep sleep");

  property p_sleepKeep;
    @(posedge clock) disable iff (!rstSync_n)
    (ctrl_q[0].enable && ctrl_q[0].keepOn) |-> compOn[0];
  endproperty
  a_sleepKeep: assert property (p_sleepKeep) else $error("kept-on comparator switched off");

  property p_pucEnable;
    @(posedge clock) disable iff (!rstSync_n)
    (powerUpClear && ctrlWr == '0) |=> (ctrl_q[0].enable && ctrl_q[1].enable);
  endproperty
  a_pucEnable: assert property (p_pucEnable) else $error("power-up clear left supervisor off");

  property p_pucFlagsOff;
    @(posedge clock) disable iff (!rstSync_n)
    (powerUpClear && !ctrl_q[1].enable && !ctrlWr[1]) |=> !flagEnable_q[1] ##1 (!flagEnable_q[1] || $past(ctrlWr[1]));
  endproperty
  a_pucFlagsOff: assert property (p_pucFlagsOff) else $error("flags live after clear of off supervisor");

  property p_writeRearm;
    @(posedge clock) disable iff (!rstSync_n)
    ctrlWr[1] |=> flagEnable_q[1];
  endproperty
  a_writeRearm: assert property (p_writeRearm) else $error("control write did not re-enable flags");

  property p_settleFlag;
    @(posedge clock) disable iff (!rstSync_n)
    (flag_q[FLAG_SETTLE] && !(flagWr && !dat_i[FLAG_SETTLE])) |=> flag_q[FLAG_SETTLE];
  endproperty
  a_settleFlag: assert property (p_settleFlag) else $error("settle flag lost without zero write");

  c_fpSettle: cover property (@(posedge clock) disable iff (!rstSync_n) expired[0] && ctrl_q[0].fullPerf);
  c_tripPor: cover property (@(posedge clock) disable iff (!rstSync_n) porRequest && flag_q[FLAG_TRIP]);
  c_pucOff: cover property (@(posedge clock) disable iff (!rstSync_n) powerUpClear && !ctrl_q[1].enable);
  c_sleepWake: cover property (@(posedge clock) disable iff (!rstSync_n) $fell(deepSleep) && settleStart[1]);

endmodule : supply_supervisor_events

// File: verif/supply_supervisor_events_tb.sv
`timescale 1ns/1ps
module supply_supervisor_events_tb;
  import supply_supervisor_pkg::*;
  // ------------------------------
  // Signals
  // ------------------------------
  localparam logic [SETTLE_CNT_W-1:0] NORM = 16'h012C;
  localparam int FP = FP_SETTLE_CYCLES;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [ADR_W-1:0] adr = '0;
  logic [31:0] wdat = '0;
  logic [31:0] rdat;
  logic ack;
  logic [SIDES-1:0] compTrip = '0;
  logic deepSleep = 1'b0;
  logic powerUpClear = 1'b0;
  logic [SIDES-1:0] compOn;
  logic porRequest;
  logic gpioHighZ;
  logic irq;
  logic [31:0] rd;
  logic [31:0] seed = 32'd38136;
  int numErrors = 0;
  int checksDone = 0;

  supply_supervisor_events #(.NormCycles(NORM), .PucSkipsSettle(1'b1)) supply_supervisor_events_inst (
    .clock(clock), .arst_n(arst_n), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .dat_i(wdat),
    .sel_i(4'hF), .dat_o(rdat), .ack_o(ack), .compTrip(compTrip), .deepSleep(deepSleep),
    .powerUpClear(powerUpClear), .compOn(compOn), .porRequest(porRequest), .gpioHighZ(gpioHighZ), .irq(irq));

  initial
  begin
    forever #4 clock = ~clock;
  end

  // ------------------------------
  // Helpers
  // ------------------------------
  function automatic logic [31:0] xorshift();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xorshift

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checksDone++;
    if (got !== exp)
    begin
      numErrors++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // Classic cycle; ack and read data taken at the rising edge that shows ack
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do
    begin
      @(posedge clock);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      chk("ack", 32'h0000_0001, 32'h0000_0000);
      completeRun();
    end
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr

  task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0000_0000, r);
    chk(name, e, r & m);
  endtask : rdchk

  task automatic cyc_wait(input int n);
    repeat (n) @(posedge clock);
  endtask : cyc_wait

  task automatic trip(input int side, input logic v);
    @(posedge clock);
    compTrip[side] <= v;
  endtask : trip

  task automatic completeRun();
    if (numErrors == 0 && checksDone > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : completeRun

  // Watchdog well beyond the few thousand cycles the sequence needs
  initial
  begin
    repeat (20000) @(posedge clock);
    numErrors++;
    completeRun();
  end

  // ------------------------------
  // Sequence
  // ------------------------------
  initial
  begin
    cyc_wait(2);
    arst_n <= 1'b1;
    cyc_wait(3);
    rdchk("ctrlHigh", CTRL_HIGH_OFS, 32'hFFFF_FFFF, 32'h0000_0001);
    rdchk("ctrlLow", CTRL_LOW_OFS, 32'hFFFF_FFFF, 32'h0000_0001);
    rdchk("irqMask", IRQ_MASK_OFS, 32'hFFFF_FFFF, 32'h0000_0000);
    rdchk("unmapped", 8'h1C, 32'hFFFF_FFFF, 32'h0000_0000);
    // Trip inside the normal mask is dropped
    trip(0, 1'b1);
    cyc_wait(100);
    trip(0, 1'b0);
    rdchk("maskedTrip", FLAG_OFS, 32'h0000_0003, 32'h0000_0000);
    cyc_wait(300);
    rdchk("settleFlags", FLAG_OFS, 32'hFFFF_FFFF, 32'h0000_000C);
    wr(FLAG_OFS, 32'h0000_000F);
    rdchk("flagKeep", FLAG_OFS, 32'hFFFF_FFFF, 32'h0000_000C);
    wr(FLAG_OFS, 32'h0000_0000);
    rdchk("flagClear", FLAG_OFS, 32'hFFFF_FFFF, 32'h0000_0000);
    // Full-performance mask is short, normal mask long
    wr(CTRL_HIGH_OFS, 32'h0000_0003);
    cyc_wait(FP - 20);
    rdchk("fpEarly", STATE_OFS, 32'h0000_0004, 32'h0000_0000);
    cyc_wait(30);
    rdchk("fpDone", STATE_OFS, 32'h0000_0004, 32'h0000_0004);
    wr(CTRL_HIGH_OFS, 32'h0000_0001);
    cyc_wait(int'(NORM) - 20);
    rdchk("normEarly", STATE_OFS, 32'h0000_0004, 32'h0000_0000);
    cyc_wait(30);
    rdchk("normDone", STATE_OFS, 32'h0000_0004, 32'h0000_0004);
    rdchk("settleSet", FLAG_OFS, 32'h0000_0004, 32'h0000_0004);
    wr(FLAG_OFS, 32'h0000_000B);
    rdchk("settleClear", FLAG_OFS, 32'h0000_0004, 32'h0000_0000);
    // Low-side trip with reset enabled, irq masked in
    wr(IRQ_MASK_OFS, 32'h0000_0002);
    wr(CTRL_LOW_OFS, 32'h0000_0005);
    cyc_wait(int'(NORM) + 10);
    wr(IRQ_STATUS_OFS, 32'h0000_000F);
    trip(1, 1'b1);
    cyc_wait(3);
    @(negedge clock);
    chk("porRequest", 1, porRequest);
    chk("irqHigh", 1, irq);
    rdchk("tripLow", FLAG_OFS, 32'h0000_0002, 32'h0000_0002);
    trip(1, 1'b0);
    wr(IRQ_STATUS_OFS, 32'h0000_000F);
    cyc_wait(3);
    @(negedge clock);
    chk("irqLow", 0, irq);
    // Trip flag still set while high side re-settles
    wr(CTRL_HIGH_OFS, 32'h0000_0001);
    cyc_wait(5);
    @(negedge clock);
    chk("highZ", 1, gpioHighZ);
    cyc_wait(int'(NORM) + 10);
    @(negedge clock);
    chk("highZEnd", 0, gpioHighZ);
    // Deep sleep gating
    @(posedge clock);
    deepSleep <= 1'b1;
    @(negedge clock);
    chk("sleepOff", 0, compOn[SIDE_HIGH]);
    wr(CTRL_HIGH_OFS, 32'h0000_0009);
    @(negedge clock);
    chk("sleepKeep", 1, compOn[SIDE_HIGH]);
    wr(CTRL_HIGH_OFS, 32'h0000_0001);
    @(posedge clock);
    deepSleep <= 1'b0;
    @(negedge clock);
    chk("wakeOn", 1, compOn[SIDE_HIGH]);
    // Power-up clear with low side disabled beforehand
    wr(CTRL_LOW_OFS, 32'h0000_0000);
    wr(FLAG_OFS, 32'h0000_0000);
    @(posedge clock);
    powerUpClear <= 1'b1;
    @(posedge clock);
    powerUpClear <= 1'b0;
    cyc_wait(3);
    rdchk("pucCtrl", CTRL_LOW_OFS, 32'hFFFF_FFFF, 32'h0000_0001);
    rdchk("pucFlagEn", STATE_OFS, 32'h0000_0030, 32'h0000_0010);
    trip(1, 1'b1);
    cyc_wait(10);
    trip(1, 1'b0);
    rdchk("pucNoFlag", FLAG_OFS, 32'h0000_0002, 32'h0000_0000);
    wr(CTRL_LOW_OFS, 32'h0000_0001);
    rdchk("reEnable", STATE_OFS, 32'h0000_0030, 32'h0000_0030);
    cyc_wait(int'(NORM) + 10);
    trip(1, 1'b1);
    cyc_wait(3);
    trip(1, 1'b0);
    rdchk("reTrip", FLAG_OFS, 32'h0000_0002, 32'h0000_0002);
    // Random mask values and unmapped writes
    repeat (6)
    begin
      rd = xorshift();
      wr(IRQ_MASK_OFS, rd);
      rdchk("maskRand", IRQ_MASK_OFS, 32'hFFFF_FFFF, rd & 32'h0000_000F);
      wr(8'h18 + 8'(rd[3:0] << 2), rd);
      rdchk("unmappedRand", 8'h18 + 8'(rd[3:0] << 2), 32'hFFFF_FFFF, 32'h0000_0000);
    end
    completeRun();
  end
endmodule : supply_supervisor_events_tb
